// File: accel_output_data_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module accel_output_data_fifo #(
   parameter int unsigned DECIM_W = 4
) (
   input  wire logic                    I_MCLK,
   input  wire logic                    I_RST,
   input  wire logic                    I_CE,
   input  wire logic                    I_LCLK,
   input  wire logic                    I_REG_REQ,
   input  wire logic                    I_REG_WRITE,
   input  wire logic                    I_REG_LAST,
   input  wire logic [7:0]              I_REG_ADDR,
   input  wire logic [7:0]              I_REG_WDATA,
   input  wire logic                    I_SAMPLE_VALID,
   input  wire afifo_pkg::axes_t        I_SAMPLE,
   input  wire logic [DECIM_W-1:0]      I_DECIM,
   input  wire logic                    I_FULL_RESOLUTION,
   input  wire logic                    I_JUSTIFY,
   input  wire logic [1:0]              I_SPAN,
   input  wire logic                    I_SLEEP,
   input  wire logic                    I_FIRST_INT_EVENT,
   input  wire logic                    I_SECOND_INT_EVENT,
   input  wire logic                    I_AUTOSLEEP_REQ,
   input  wire logic                    I_ACTIVITY_PENDING,
   output logic [7:0]                   O_REG_RDATA,
   output logic                         O_REG_ACK,
   output logic                         O_REG_BUSY,
   output logic                         O_DATA_READY,
   output logic                         O_WATERMARK,
   output logic                         O_OVERRUN,
   output logic                         O_ACT_VALID,
   output afifo_pkg::axes_t             O_ACT_SAMPLE,
   output logic                         O_SLEEP_ALLOWED,
   output logic                         O_INT_SOURCE_READ
);

   // Scale, clip and align one raw full-resolution word
   function automatic logic [15:0] format_word(input logic [15:0] raw, input logic hi_res,
                                               input logic justify, input logic [1:0] span);
      logic signed [15:0] scaled;
      logic signed [15:0] hi_lim;
      logic signed [15:0] lo_lim;
      logic [4:0]         width;
      logic [4:0]         shift;
      scaled = hi_res ? $signed(raw) : ($signed(raw) >>> span);
      width  = hi_res ? 5'(afifo_pkg::BASE_WIDTH) + {3'h0, span}
                        : 5'(afifo_pkg::BASE_WIDTH);
      shift  = 5'h10 - width;
      hi_lim = 16'sh7fff >>> shift;
      lo_lim = ~hi_lim;
      if (scaled > hi_lim) begin
         scaled = hi_lim;
      end else if (scaled < lo_lim) begin
         scaled = lo_lim;
      end
      return justify ? (16'(scaled) << shift) : 16'(scaled);
   endfunction

   function automatic logic is_data_addr(input logic [7:0] addr);
      return (addr >= afifo_pkg::ADDR_X_LOW) && (addr <= afifo_pkg::ADDR_Z_HIGH);
   endfunction

   // Low byte at the lower address of each axis pair
   function automatic logic [7:0] pick_byte(input afifo_pkg::axes_t s, input logic [7:0] addr);
      logic [7:0] b;
      b = 8'h00;
      case (addr)
         afifo_pkg::ADDR_X_LOW:  b = s.x[7:0];
         afifo_pkg::ADDR_X_HIGH: b = s.x[15:8];
         afifo_pkg::ADDR_Y_LOW:  b = s.y[7:0];
         afifo_pkg::ADDR_Y_HIGH: b = s.y[15:8];
         afifo_pkg::ADDR_Z_LOW:  b = s.z[7:0];
         afifo_pkg::ADDR_Z_HIGH: b = s.z[15:8];
         default:                b = 8'h00;
      endcase
      return b;
   endfunction

   // Link-domain state
   afifo_pkg::link_state_t   link_state;
   afifo_pkg::link_state_t   next_link_state;
   afifo_pkg::reg_req_t      lreq;
   afifo_pkg::reg_req_t      next_lreq;
   logic                     req_tgl;
   logic                     next_req_tgl;
   logic                     busy;
   logic                     next_busy;
   logic                     ack;
   logic                     next_ack;
   logic [7:0]               link_rdata;
   logic [7:0]               next_link_rdata;
   logic                     ack_s1;
   logic                     ack_s2;
   logic                     ack_s3;
   logic                     ack_seen;

   // Main-domain state
   afifo_pkg::axes_t         mem [afifo_pkg::QUEUE_DEPTH];
   logic [afifo_pkg::PTR_W-1:0]   rd_ptr;
   logic [afifo_pkg::PTR_W-1:0]   next_rd_ptr;
   logic [afifo_pkg::PTR_W-1:0]   wr_ptr;
   logic [afifo_pkg::PTR_W-1:0]   next_wr_ptr;
   logic [afifo_pkg::COUNT_W-1:0] count;
   logic [afifo_pkg::COUNT_W-1:0] next_count;
   logic [afifo_pkg::COUNT_W-1:0] count_after;
   logic [afifo_pkg::COUNT_W-1:0] threshold;
   afifo_pkg::axes_t         out_sample;
   afifo_pkg::axes_t         next_out_sample;
   afifo_pkg::axes_t         formatted;
   afifo_pkg::axes_t         act_sample;
   afifo_pkg::axes_t         next_act_sample;
   logic                     out_valid;
   logic                     next_out_valid;
   logic [7:0]               ctl;
   logic [7:0]               next_ctl;
   logic [1:0]               mode;
   logic                     trig_seen;
   logic                     next_trig_seen;
   logic                     trig_event;
   logic                     overrun;
   logic                     next_overrun;
   logic                     watermark;
   logic                     next_watermark;
   logic [DECIM_W-1:0]       decim_cnt;
   logic [DECIM_W-1:0]       next_decim_cnt;
   logic                     data_touched;
   logic                     next_data_touched;
   logic [7:0]               rdata;
   logic [7:0]               next_rdata;
   logic [7:0]               isrc;
   logic                     ack_tgl;
   logic                     next_ack_tgl;
   logic                     req_s1;
   logic                     req_s2;
   logic                     req_s3;
   logic                     req_seen;
   logic                     act_valid;
   logic                     next_act_valid;
   logic                     sleep_allowed;
   logic                     next_sleep_allowed;
   logic                     isrc_read;
   logic                     next_isrc_read;
   logic                     take;
   logic                     wr_en;
   logic                     drop;
   logic                     refill;
   logic                     data_end;
   logic                     full;

   // Link side: capture a request, hand it over by toggle, wait for the answer
   always_comb begin
      next_link_state = link_state;
      next_lreq       = lreq;
      next_req_tgl    = req_tgl;
      next_busy       = busy;
      next_ack        = 1'b0;
      next_link_rdata = link_rdata;
      ack_seen        = ack_s2 ^ ack_s3;
      unique case (link_state)
         afifo_pkg::LINK_IDLE: begin
            if (I_REG_REQ && !ack) begin // Request held into the answer cycle is not taken twice
               next_lreq       = '{write: I_REG_WRITE, last: I_REG_LAST,
                                   addr: I_REG_ADDR, wdata: I_REG_WDATA};
               next_req_tgl    = ~req_tgl;
               next_busy       = 1'b1;
               next_link_state = afifo_pkg::LINK_WAIT;
            end
         end
         afifo_pkg::LINK_WAIT: begin
            if (ack_seen) begin
               next_link_rdata = rdata;
               next_ack        = 1'b1;
               next_busy       = 1'b0;
               next_link_state = afifo_pkg::LINK_IDLE;
            end
         end
         default: next_link_state = afifo_pkg::LINK_IDLE;
      endcase
   end

   // Link side registers and answer synchroniser
   always_ff @(posedge I_LCLK or posedge I_RST) begin
      if (I_RST) begin
         link_state <= afifo_pkg::LINK_IDLE;
         lreq       <= '0;
         req_tgl    <= 1'b0;
         busy       <= 1'b0;
         ack        <= 1'b0;
         link_rdata <= 8'h00;
         ack_s1     <= 1'b0;
         ack_s2     <= 1'b0;
         ack_s3     <= 1'b0;
      end else begin
         link_state <= next_link_state;
         lreq       <= next_lreq;
         req_tgl    <= next_req_tgl;
         busy       <= next_busy;
         ack        <= next_ack;
         link_rdata <= next_link_rdata;
         ack_s1     <= ack_tgl;
         ack_s2     <= ack_s1;
         ack_s3     <= ack_s2;
      end
   end

   assign O_REG_RDATA = link_rdata;
   assign O_REG_ACK   = ack;
   assign O_REG_BUSY  = busy;

   // Main side: register access, sample path and queue bookkeeping
   always_comb begin
      next_ctl           = ctl;
      next_trig_seen     = trig_seen;
      next_overrun       = overrun;
      next_out_sample    = out_sample;
      next_out_valid     = out_valid;
      next_decim_cnt     = decim_cnt;
      next_data_touched  = data_touched;
      next_rdata         = rdata;
      next_ack_tgl       = ack_tgl;
      next_isrc_read     = 1'b0;
      next_act_valid     = I_SAMPLE_VALID;
      next_act_sample    = I_SAMPLE_VALID ? I_SAMPLE : act_sample;
      next_sleep_allowed = I_AUTOSLEEP_REQ && !I_ACTIVITY_PENDING;
      mode               = ctl[afifo_pkg::MODE_HI:afifo_pkg::MODE_LO];
      threshold          = {1'b0, ctl[afifo_pkg::COUNT_HI:0]};
      req_seen           = req_s2 ^ req_s3;
      take               = 1'b0;
      wr_en              = 1'b0;
      drop               = 1'b0;
      refill             = 1'b0;
      data_end           = 1'b0;
      formatted.x        = format_word(I_SAMPLE.x, I_FULL_RESOLUTION, I_JUSTIFY, I_SPAN);
      formatted.y        = format_word(I_SAMPLE.y, I_FULL_RESOLUTION, I_JUSTIFY, I_SPAN);
      formatted.z        = format_word(I_SAMPLE.z, I_FULL_RESOLUTION, I_JUSTIFY, I_SPAN);
      isrc               = 8'h00;
      isrc[afifo_pkg::ISRC_READY_BIT] = out_valid;
      isrc[afifo_pkg::ISRC_WMARK_BIT] = watermark;
      isrc[afifo_pkg::ISRC_OVR_BIT]   = overrun;
      // Decimated output stream, none pushed in sleep
      if (I_SAMPLE_VALID && !I_SLEEP) begin
         if (decim_cnt == I_DECIM) begin
            next_decim_cnt = '0;
            take           = 1'b1;
         end else begin
            next_decim_cnt = decim_cnt + DECIM_W'(1);
         end
      end
      // Register access handed over from the link side
      if (req_seen) begin
         next_ack_tgl = ~ack_tgl;
         if (lreq.write) begin
            if (lreq.addr == afifo_pkg::ADDR_QUEUE_CTL) begin
               next_ctl       = lreq.wdata;
               next_trig_seen = 1'b0;
            end
         end else begin
            case (lreq.addr)
               afifo_pkg::ADDR_QUEUE_CTL:  next_rdata = ctl;
               afifo_pkg::ADDR_QUEUE_STAT: next_rdata = {trig_seen, 1'b0, count};
               afifo_pkg::ADDR_INT_SOURCE: begin
                  next_rdata     = isrc;
                  next_isrc_read = 1'b1;
               end
               default:                    next_rdata = pick_byte(out_sample, lreq.addr);
            endcase
         end
         if (lreq.last) begin
            data_end          = data_touched || (!lreq.write && is_data_addr(lreq.addr));
            next_data_touched = 1'b0;
         end else if (!lreq.write && is_data_addr(lreq.addr)) begin
            next_data_touched = 1'b1;
         end
      end
      // A completed data read frees the output stage
      if (data_end) begin
         next_out_valid = 1'b0;
         next_overrun   = 1'b0;
      end
      // Output stage holds one extra entry beyond the queue
      if (mode != afifo_pkg::MODE_BYPASS && (!out_valid || data_end) && count != '0) begin
         refill          = 1'b1;
         next_out_sample = mem[rd_ptr];
         next_out_valid  = 1'b1;
      end
      count_after = count - afifo_pkg::COUNT_W'(refill);
      full        = count_after == afifo_pkg::COUNT_W'(afifo_pkg::QUEUE_DEPTH);
      if (take) begin
         if (mode == afifo_pkg::MODE_BYPASS) begin
            next_out_sample = formatted;
            next_out_valid  = 1'b1;
         end else if (mode == afifo_pkg::MODE_STREAM) begin
            wr_en = 1'b1;
            if (full) begin
               drop         = 1'b1;
               next_overrun = 1'b1;
            end
         end else if (mode == afifo_pkg::MODE_TRIGGER && !trig_seen) begin
            wr_en = 1'b1;
            if (count_after != '0 && count_after >= threshold) begin
               drop = 1'b1;
            end
         end else begin
            if (full) begin
               next_overrun = 1'b1;
            end else begin
               wr_en = 1'b1;
            end
         end
      end
      next_wr_ptr = wr_ptr + afifo_pkg::PTR_W'(wr_en);
      next_rd_ptr = rd_ptr + afifo_pkg::PTR_W'(refill) + afifo_pkg::PTR_W'(drop);
      next_count  = count_after + afifo_pkg::COUNT_W'(wr_en) - afifo_pkg::COUNT_W'(drop);
      if (mode == afifo_pkg::MODE_BYPASS) begin
         next_rd_ptr = wr_ptr;
         next_count  = '0;
      end
      // Watermark follows the level, so draining reads clear it
      next_watermark = (threshold == '0) ||
                       ((mode == afifo_pkg::MODE_FIFO || mode == afifo_pkg::MODE_STREAM) &&
                        next_count >= threshold);
      // Trigger event wins over a clearing control write
      trig_event = ctl[afifo_pkg::TRIG_SRC_BIT] ? I_SECOND_INT_EVENT : I_FIRST_INT_EVENT;
      if (mode == afifo_pkg::MODE_TRIGGER && trig_event) begin
         next_trig_seen = 1'b1;
      end
   end

   // Main side registers, frozen while the clock enable is low
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         ctl           <= afifo_pkg::QUEUE_CTL_RESET;
         trig_seen     <= 1'b0;
         overrun       <= 1'b0;
         watermark     <= 1'b0;
         out_sample    <= '0;
         out_valid     <= 1'b0;
         rd_ptr        <= '0;
         wr_ptr        <= '0;
         count         <= '0;
         decim_cnt     <= '0;
         data_touched  <= 1'b0;
         rdata         <= 8'h00;
         ack_tgl       <= 1'b0;
         req_s1        <= 1'b0;
         req_s2        <= 1'b0;
         req_s3        <= 1'b0;
         act_valid     <= 1'b0;
         act_sample    <= '0;
         sleep_allowed <= 1'b0;
         isrc_read     <= 1'b0;
      end else if (I_CE) begin
         ctl           <= next_ctl;
         trig_seen     <= next_trig_seen;
         overrun       <= next_overrun;
         watermark     <= next_watermark;
         out_sample    <= next_out_sample;
         out_valid     <= next_out_valid;
         rd_ptr        <= next_rd_ptr;
         wr_ptr        <= next_wr_ptr;
         count         <= next_count;
         decim_cnt     <= next_decim_cnt;
         data_touched  <= next_data_touched;
         rdata         <= next_rdata;
         ack_tgl       <= next_ack_tgl;
         req_s1        <= req_tgl;
         req_s2        <= req_s1;
         req_s3        <= req_s2;
         act_valid     <= next_act_valid;
         act_sample    <= next_act_sample;
         sleep_allowed <= next_sleep_allowed;
         isrc_read     <= next_isrc_read;
      end
   end

   // Queue storage, one x, y, z set per entry
   always_ff @(posedge I_MCLK) begin
      if (I_CE && wr_en) begin
         mem[wr_ptr] <= formatted;
      end
   end

   assign O_DATA_READY      = out_valid;
   assign O_WATERMARK       = watermark;
   assign O_OVERRUN         = overrun;
   assign O_ACT_VALID       = act_valid;
   assign O_ACT_SAMPLE      = act_sample;
   assign O_SLEEP_ALLOWED   = sleep_allowed;
   assign O_INT_SOURCE_READ = isrc_read;

   // Checks
   sequence data_read_end_s;
      I_CE && req_seen && lreq.last && !lreq.write &&
      (data_touched || is_data_addr(lreq.addr));
   endsequence

   sequence quiet_step_s;
      I_CE && !req_seen && out_valid;
   endsequence

   property pop_one_p;
      @(posedge I_MCLK) disable iff (I_RST)
      data_read_end_s ##0 (!take && count != '0 && mode != afifo_pkg::MODE_BYPASS)
      |=> (count == $past(count) - 6'h01) && out_valid;
   endproperty

   count_limit_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
      count <= 6'h20)
      else $error("queue count above depth");

   fifo_stop_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
      quiet_step_s ##0 (mode == afifo_pkg::MODE_FIFO && count == 6'h20 && take)
      |=> count == 6'h20 && overrun && rd_ptr == $past(rd_ptr))
      else $error("fifo mode stored into a full queue");

   stream_keep_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
      quiet_step_s ##0 (mode == afifo_pkg::MODE_STREAM && count == 6'h20 && take)
      |=> count == 6'h20 && rd_ptr == $past(rd_ptr) + 5'h01 && overrun)
      else $error("stream mode did not drop the oldest");

   bypass_empty_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
      I_CE && mode == afifo_pkg::MODE_BYPASS && take && !data_end
      |=> count == '0 && out_valid && out_sample == $past(formatted))
      else $error("bypass sample did not reach output");

   zero_wmark_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
      I_CE && ctl[afifo_pkg::COUNT_HI:0] == 5'h00 |=> watermark)
      else $error("zero count did not set watermark");

   trig_flag_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
      I_CE && mode == afifo_pkg::MODE_TRIGGER && trig_event |=> trig_seen)
      else $error("trigger event not flagged");

   sleep_hold_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
      quiet_step_s ##0 (I_SLEEP && mode != afifo_pkg::MODE_BYPASS) |=> $stable(count))
      else $error("queue changed during sleep");

   pop_level_a: assert property (pop_one_p)
      else $error("data read did not remove one level");

   sleep_block_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
      I_CE && I_ACTIVITY_PENDING |=> !O_SLEEP_ALLOWED)
      else $error("sleep allowed with activity pending");

   link_ack_a: assert property (@(posedge I_LCLK) disable iff (I_RST)
      O_REG_ACK |-> !O_REG_BUSY ##1 !O_REG_ACK)
      else $error("answer pulse malformed");

   link_refuse_a: assert property (@(posedge I_LCLK) disable iff (I_RST)
      O_REG_ACK |=> !O_REG_BUSY)
      else $error("request taken in answer cycle");

endmodule
`default_nettype wire

// File: afifo_pkg.sv
// How it works
// - Alignment bit 1 gives MSB-aligned words, 0 gives LSB-aligned sign-extended words.
// - Span code 00/01/10/11 selects +-0.5, +-1, +-2, +-4 g.
// - Six read-only axis bytes: x at 0x32/0x33, y 0x34/0x35, z 0x36/0x37.
// - Axis values are two's complement; lower address holds low byte.
// - Queue mode in D7:D6; code 00 is bypass, samples go straight to output.
// - Mode 01 stores up to 32 samples, then stops; accepts only when not full.
// - Mode 10 keeps newest 32 samples; when full the oldest is replaced.
// - Mode 11 keeps pre-trigger samples, then stores until full after the trigger.
// - Trigger source bit 0 ties trigger to first interrupt, 1 to second.
// - A zero sample count sets the watermark flag at once, in any mode.
// - In modes 01 and 10 the count is the watermark level; bypass ignores it.
// - In trigger mode the count is the pre-trigger depth; host avoids zero.
// - Trigger-seen flag in status D7 reads 1 after a trigger event.
// - Status register reports the number of stored entries.
// - Any data read, single or burst, removes one level; host reads in bursts.
// - Queue holds 32 entries plus one at the output stage, 33 in all.
// - Output rate comes from decimation; activity sees undecimated samples.
// - Host clears interrupts via 0x30; uncleared activity blocks automatic sleep.
// - New-sample and watermark flags clear by data reads, maybe several.
// - In sleep the device pushes no samples into the queue.
// - Full resolution widens words with span at 1024 LSB/g; else 10 bits.
package afifo_pkg;
   localparam int unsigned QUEUE_DEPTH     = 32;
   localparam int unsigned COUNT_W         = 6;
   localparam int unsigned PTR_W           = 5;
   localparam int unsigned WORD_W          = 16;
   localparam int unsigned BASE_WIDTH      = 10;

   localparam logic [7:0] ADDR_INT_SOURCE  = 8'h30;
   localparam logic [7:0] ADDR_X_LOW       = 8'h32;
   localparam logic [7:0] ADDR_X_HIGH      = 8'h33;
   localparam logic [7:0] ADDR_Y_LOW       = 8'h34;
   localparam logic [7:0] ADDR_Y_HIGH      = 8'h35;
   localparam logic [7:0] ADDR_Z_LOW       = 8'h36;
   localparam logic [7:0] ADDR_Z_HIGH      = 8'h37;
   localparam logic [7:0] ADDR_QUEUE_CTL   = 8'h38;
   localparam logic [7:0] ADDR_QUEUE_STAT  = 8'h39;

   localparam logic [7:0] QUEUE_CTL_RESET  = 8'h00;
   localparam int unsigned MODE_HI         = 7;
   localparam int unsigned MODE_LO         = 6;
   localparam int unsigned TRIG_SRC_BIT    = 5;
   localparam int unsigned COUNT_HI        = 4;
   localparam int unsigned TRIG_SEEN_BIT   = 7;
   localparam int unsigned ISRC_READY_BIT  = 7;
   localparam int unsigned ISRC_WMARK_BIT  = 1;
   localparam int unsigned ISRC_OVR_BIT    = 0;

   localparam logic [1:0] MODE_BYPASS      = 2'h0;
   localparam logic [1:0] MODE_FIFO        = 2'h1;
   localparam logic [1:0] MODE_STREAM      = 2'h2;
   localparam logic [1:0] MODE_TRIGGER     = 2'h3;

   localparam logic [1:0] SPAN_HALF_G      = 2'h0;
   localparam logic [1:0] SPAN_1G          = 2'h1;
   localparam logic [1:0] SPAN_2G          = 2'h2;
   localparam logic [1:0] SPAN_4G          = 2'h3;

   // One x, y, z sample set
   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } axes_t;

   // Register access carried from the link side
   typedef struct packed {
      logic       write;
      logic       last;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [1:0] {
      LINK_IDLE = 2'b01,
      LINK_WAIT = 2'b10
   } link_state_t;
endpackage

// File: host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
   input  wire logic          i_lclk,
   input  wire logic          i_ack,
   input  wire logic [7:0]    i_rdata,
   output logic               o_req,
   output afifo_pkg::reg_req_t o_cmd
);
   initial begin
      o_req = 1'b0;
      o_cmd = '0;
   end
   // One access, held until the ack edge; the burst end flag ends a read burst
   task automatic access(input logic wr, input logic lst, input logic [7:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      @(posedge i_lclk);
      o_req <= 1'b1;
      o_cmd <= '{wr, lst, a, d};
      // A missing answer hangs here and is caught by the bench timeout
      do begin
         @(posedge i_lclk);
      end while (i_ack !== 1'b1);
      q = i_rdata;
      o_req <= 1'b0;
      o_cmd <= ~o_cmd; // Released lines show the inverse
   endtask
endmodule
`default_nettype wire

// File: tb_accel_output_data_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tb_accel_output_data_fifo;
   logic                mclk = 1'b0;
   logic                lclk = 1'b0;
   logic                rst = 1'b1;
   logic                valid = 1'b0;
   logic                justify = 1'b0;
   logic [3:0]          misc = 4'h0;
   logic                req;
   logic                ack;
   logic [7:0]          rdata;
   logic [7:0]          q;
   afifo_pkg::reg_req_t cmd;
   logic                sleep = 1'b0;
   logic [2:0]          flags;
   logic                slp;
   afifo_pkg::axes_t    act;
   afifo_pkg::axes_t    smp = '0;
   afifo_pkg::axes_t    sent[$];
   int                  err_count = 0;
   int                  samples_checked = 0;
   int                  seed = 98;
   int                  cycles = 0;
   initial forever #10 mclk = ~mclk;
   initial begin
      #7;
      forever #62.5 lclk = ~lclk;
   end
   accel_output_data_fifo i_accel_output_data_fifo (.I_MCLK(mclk), .I_RST(rst), .I_CE(1'b1),
      .I_LCLK(lclk), .I_REG_REQ(req), .I_REG_WRITE(cmd.write), .I_REG_LAST(cmd.last),
      .I_REG_ADDR(cmd.addr), .I_REG_WDATA(cmd.wdata), .I_SAMPLE_VALID(valid), .I_SAMPLE(smp),
      .I_DECIM(4'h0), .I_FULL_RESOLUTION(1'b1), .I_JUSTIFY(justify), .I_SPAN(2'h3),
      .I_SLEEP(sleep), .I_FIRST_INT_EVENT(misc[0]), .I_SECOND_INT_EVENT(misc[1]),
      .I_AUTOSLEEP_REQ(misc[2]), .I_ACTIVITY_PENDING(misc[3]), .O_REG_RDATA(rdata),
      .O_REG_ACK(ack), .O_REG_BUSY(), .O_DATA_READY(flags[2]), .O_WATERMARK(flags[1]),
      .O_OVERRUN(flags[0]), .O_ACT_VALID(), .O_ACT_SAMPLE(act), .O_SLEEP_ALLOWED(slp),
      .O_INT_SOURCE_READ());
   host_link_model i_host_link_model (.i_lclk(lclk), .i_ack(ack), .i_rdata(rdata),
      .o_req(req), .o_cmd(cmd));
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic lst);
      i_host_link_model.access(1'b0, lst, a, 8'h00, q);
   endtask
   task automatic wr(input logic [7:0] d);
      i_host_link_model.access(1'b1, 1'b1, 8'h38, d, q);
   endtask
   // Random 13-bit signed samples, one-cycle valid pulses
   task automatic push(input int n, input logic [3:0] mask);
      afifo_pkg::axes_t a;
      repeat (n) begin
         a = {16'($random(seed) % 4096), 16'($random(seed) % 4096), 16'($random(seed) % 4096)};
         sent.push_back(a);
         @(posedge mclk);
         valid <= 1'b1;
         smp <= a;
         misc <= 4'($random(seed)) & mask;
         @(posedge mclk);
         valid <= 1'b0;
      end
      repeat (8) @(posedge mclk);
   endtask
   // Six-byte burst, low byte at even address, left justify shifts 13 bits up by 3
   task automatic burst(input afifo_pkg::axes_t e);
      logic [15:0] v;
      for (int i = 0; i < 6; i++) begin
         rd(8'h32 + 8'(i), i == 5);
         v = (i < 2) ? e.x : (i < 4) ? e.y : e.z;
         v = justify ? v << 3 : v;
         check("axis byte", {8'h00, (i % 2) ? v[15:8] : v[7:0]}, {8'h00, q});
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(8'h38, 1'b1);
      check("control reset", 16'h0000, {8'h00, q});
      rd(8'h30, 1'b1);
      check("zero count watermark", 16'h0002, {8'h00, q & 8'h02});
      push(1, 4'hf);
      burst(sent[$]);
      $display("done bypass");
      sent.delete();
      for (int m = 1; m < 3; m++) begin
         wr(8'(m << 6 | 4));
         rd(8'h38, 1'b1);
         check("control readback", 16'(m << 6 | 4), {8'h00, q});
         @(posedge mclk) justify <= 1'b1;
         push(40, 4'hf);
         check("status outputs", 16'h0007, {13'h0000, flags});
         check("activity sample", sent[$].x, act.x);
         check("sleep allowed", {15'h0000, misc[2] & ~misc[3]}, {15'h0000, slp});
         rd(8'h39, 1'b1);
         check("entries", 16'd32, {8'h00, q & 8'h3f});
         rd(8'h30, 1'b1);
         check("interrupt source", 16'h0083, {8'h00, q});
         burst(sent[m - 1]);
         if (m == 2) begin
            burst(sent[48]);
         end
         rd(8'h39, 1'b1);
         check("entries after pop", 16'(32 - m), {8'h00, q & 8'h3f});
         $display("done mode %0d", m);
      end
      wr(8'h00);
      rd(8'h39, 1'b1);
      check("bypass flush", 16'd0, {8'h00, q & 8'h3f});
      // Trigger mode: sleep first, then a wrong-source event, then the real trigger
      @(posedge mclk) begin
         misc <= 4'h0;
         sleep <= 1'b1;
      end
      wr(8'hc4);
      push(3, 4'h0);
      rd(8'h39, 1'b1);
      check("entries in sleep", 16'h0000, {8'h00, q});
      @(posedge mclk) begin
         sleep <= 1'b0;
         misc <= 4'h2;
      end
      push(10, 4'h0);
      rd(8'h39, 1'b1);
      check("pre-trigger entries", 16'h0004, {8'h00, q});
      @(posedge mclk) misc <= 4'h1;
      push(40, 4'h0);
      rd(8'h39, 1'b1);
      check("post-trigger entries", 16'h00a0, {8'h00, q});
      $display("done trigger");
      end_of_test();
   end
endmodule
`default_nettype wire
